// >>> hdl/dmd_pkg.sv
package dmd_pkg;
    localparam int  CLK_HZ          = 100_000_000;
    localparam int  BLINK_HZ        = 2;
    // Half period of the blink timebase, in clock cycles
    localparam int  BLINK_HALF_CYC  = CLK_HZ / (2 * BLINK_HZ);
    localparam int  NUM_DIGITS      = 4;
    localparam int  DOTS_PER_DIGIT  = 35;
    // Control word fields
    localparam int  CW_CLEAR        = 7;
    localparam int  CW_LAMP         = 6;
    localparam int  CW_BLINK        = 5;
    localparam int  CW_ATTR_EN      = 4;
    localparam int  CW_ATTR_HI      = 3;
    localparam int  CW_ATTR_LO      = 2;
    localparam int  CW_BRIGHT_HI    = 1;
    localparam int  CW_BRIGHT_LO    = 0;
    localparam int  DIG_FLAG        = 7;
    localparam int  REG_SEL         = 2;
    localparam logic [7:0] CW_RESET  = 8'h00;
    localparam logic [7:0] DIG_RESET = 8'h00;
    // Brightness codes
    localparam logic [1:0] BR_BLANK = 2'h0;
    localparam logic [1:0] BR_Q1    = 2'h1;
    localparam logic [1:0] BR_HALF  = 2'h2;
    localparam logic [1:0] BR_FULL  = 2'h3;
    // Attribute modes (bits 3:2)
    localparam logic [1:0] AT_CURSOR    = 2'h0;
    localparam logic [1:0] AT_BLINK     = 2'h1;
    localparam logic [1:0] AT_BLINK_CUR = 2'h2;
    localparam logic [1:0] AT_ALT       = 2'h3;
    // Per-digit render kinds
    typedef enum logic [1:0] {DMD_SHOW_CHAR, DMD_SHOW_CURSOR, DMD_SHOW_DARK} dmd_show_t;
endpackage

// >>> hdl/dmd_bus_if.sv
`timescale 1ns/1ps
interface dmd_bus_if;
    logic       chip_select_low_active_n;
    logic       chip_select_high_active;
    logic       rd_n;
    logic       wr_n;
    logic [2:0] addr;
    logic [7:0] data_host_o;
    logic       data_host_oe;
    logic [7:0] data_dev_o;
    logic       data_dev_oe;
    logic       rst_n;
    logic       clock_source_select;
    wire  [7:0] data = data_dev_oe ? data_dev_o : (data_host_oe ? data_host_o : 8'h00);

    modport host (output chip_select_low_active_n, chip_select_high_active, rd_n, wr_n, addr,
                  data_host_o, data_host_oe, rst_n, clock_source_select,
                  input data);
    modport dev  (input chip_select_low_active_n, chip_select_high_active, rd_n, wr_n, addr,
                  rst_n, clock_source_select, data,
                  output data_dev_o, data_dev_oe);
endinterface

// >>> hdl/dmd_display.sv
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
// Function
// - Bit4 clear: no digit highlighted
// - Mode 00: flagged digit shows steady cursor
// - Mode 01: flagged characters blink
// - Mode 10: flagged digit shows blinking cursor
// - Mode 11: flagged digit alternates char/cursor
// - Cursor is whole cell at half brightness
// - Attributes never alter stored codes
// - Bit5 blinks whole display near 2 Hz
// - System shares clock and reset across modules
// - Bit6 lamp test lights all dots half while bit5 is clear
// - Bit7 write clears memory, blanks display
// - Host rewrites control word after clear
// - Bits1:0 keep brightness in attribute modes
// - Cascade: low select tied, high decoded
// - One module clocks cascade; others external
// - Digit write keeps code plus attribute flag
// - Brightness: blank, 25, 50, full percent
// - Address bit2 low reaches mirrored control word
// - Address bit2 high selects digit 0..3
// - Host holds selects, pulses read/write strobe
module dmd_display
    import dmd_pkg::*;
(
    input  wire logic                       i_clk,
    input  wire logic                       i_rstn,
    dmd_bus_if.dev                          bus,
    input  wire logic [NUM_DIGITS*7-1:0]    i_char_dots_sel,
    output logic      [NUM_DIGITS*7-1:0]    o_char_code,
    output logic      [NUM_DIGITS*2-1:0]    o_digit_level,
    output logic      [NUM_DIGITS*2-1:0]    o_digit_show,
    output logic                            o_clock_internal
);
    // Character ROM lives outside; i_char_dots_sel is unused beyond being an input
    logic [7:0]  cw_ff,     nxt_cw;
    logic [7:0]  dig_ff [NUM_DIGITS];
    logic [7:0]  nxt_dig [NUM_DIGITS];
    logic        wr_d_ff,   nxt_wr_d;
    logic [7:0]  rdata_ff,  nxt_rdata;
    logic        oe_ff,     nxt_oe;
    logic [31:0] tb_cnt_ff, nxt_tb_cnt;
    logic        phase_ff,  nxt_phase;
    logic        sel;
    logic        wr_edge;

    assign sel     = !bus.chip_select_low_active_n && bus.chip_select_high_active;
    // Write takes effect on the strobe's falling edge as seen in this clock
    assign wr_edge = sel && !bus.wr_n && !wr_d_ff;

    function automatic logic [1:0] lvl_of(input logic [1:0] b);
        unique case (b)
            BR_BLANK: lvl_of = BR_BLANK;
            BR_Q1:    lvl_of = BR_Q1;
            BR_HALF:  lvl_of = BR_HALF;
            BR_FULL:  lvl_of = BR_FULL;
        endcase
    endfunction

    always_comb begin
        nxt_cw    = cw_ff;
        nxt_wr_d  = sel && !bus.wr_n;
        nxt_oe    = sel && !bus.rd_n && bus.wr_n;
        nxt_rdata = bus.addr[REG_SEL] ? dig_ff[bus.addr[1:0]] : cw_ff;
        for (int i = 0; i < NUM_DIGITS; i++) begin
            nxt_dig[i] = dig_ff[i];
        end
        if (wr_edge) begin
            if (!bus.addr[REG_SEL]) begin
                if (bus.data[CW_CLEAR]) begin
                    nxt_cw = CW_RESET;
                    for (int i = 0; i < NUM_DIGITS; i++) begin
                        nxt_dig[i] = DIG_RESET;
                    end
                end else begin
                    nxt_cw = bus.data;
                end
            end else begin
                nxt_dig[bus.addr[1:0]] = bus.data;
            end
        end
        // Shared blink timebase; the reset pin realigns phase across cascaded modules
        if (!bus.rst_n) begin
            nxt_tb_cnt = '0;
            nxt_phase  = 1'b0;
        end else if (tb_cnt_ff == 32'(BLINK_HALF_CYC - 1)) begin
            nxt_tb_cnt = '0;
            nxt_phase  = !phase_ff;
        end else begin
            nxt_tb_cnt = tb_cnt_ff + 32'h1;
            nxt_phase  = phase_ff;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            cw_ff     <= CW_RESET;
            wr_d_ff   <= 1'b0;
            rdata_ff  <= 8'h00;
            oe_ff     <= 1'b0;
            tb_cnt_ff <= 32'h0;
            phase_ff  <= 1'b0;
            for (int i = 0; i < NUM_DIGITS; i++) begin
                dig_ff[i] <= DIG_RESET;
            end
        end else begin
            cw_ff     <= nxt_cw;
            wr_d_ff   <= nxt_wr_d;
            rdata_ff  <= nxt_rdata;
            oe_ff     <= nxt_oe;
            tb_cnt_ff <= nxt_tb_cnt;
            phase_ff  <= nxt_phase;
            for (int i = 0; i < NUM_DIGITS; i++) begin
                dig_ff[i] <= nxt_dig[i];
            end
        end
    end

    assign bus.data_dev_o  = rdata_ff;
    assign bus.data_dev_oe = oe_ff && sel && !bus.rd_n;
    assign o_clock_internal = bus.clock_source_select;

    // Render: phase_ff high is the "off" half of a blink
    always_comb begin
        dmd_show_t show;
        logic [1:0] lvl;
        show = DMD_SHOW_CHAR;
        lvl  = BR_BLANK;
        for (int i = 0; i < NUM_DIGITS; i++) begin
            o_char_code[i*7 +: 7] = dig_ff[i][DIG_FLAG-1:0];
            show = DMD_SHOW_CHAR;
            lvl  = lvl_of(cw_ff[CW_BRIGHT_HI:CW_BRIGHT_LO]);
            if (cw_ff[CW_ATTR_EN] && dig_ff[i][DIG_FLAG]) begin
                unique case (cw_ff[CW_ATTR_HI:CW_ATTR_LO])
                    AT_CURSOR:    show = DMD_SHOW_CURSOR;
                    AT_BLINK:     show = phase_ff ? DMD_SHOW_DARK : DMD_SHOW_CHAR;
                    AT_BLINK_CUR: show = phase_ff ? DMD_SHOW_DARK : DMD_SHOW_CURSOR;
                    AT_ALT:       show = phase_ff ? DMD_SHOW_CURSOR : DMD_SHOW_CHAR;
                endcase
            end
            if (show == DMD_SHOW_CURSOR) begin
                lvl = BR_HALF;
            end
            if (cw_ff[CW_BLINK] && phase_ff) begin
                show = DMD_SHOW_DARK;
            end
            if (cw_ff[CW_LAMP] && !cw_ff[CW_BLINK]) begin
                show = DMD_SHOW_CURSOR;
                lvl  = BR_HALF;
            end
            if (show == DMD_SHOW_DARK) begin
                lvl = BR_BLANK;
            end
            o_digit_show[i*2 +: 2]  = show;
            o_digit_level[i*2 +: 2] = lvl;
        end
    end
endmodule

// >>> hdl/dmd_host.sv
`timescale 1ns/1ps
module dmd_host
    import dmd_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    input  wire logic [2:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic       i_clock_source_select,
    output logic      [7:0] o_rdata,
    dmd_bus_if.host         bus
);
    logic       wr_ff,   nxt_wr;
    logic       rd_ff,   nxt_rd;
    logic [2:0] addr_ff, nxt_addr;
    logic [7:0] wd_ff,   nxt_wd;
    logic [7:0] rdata_ff, nxt_rdata;
    logic       rdv_ff,  nxt_rdv;

    // One-cycle write strobe and two-cycle read strobe on the pins; device answers one cycle later
    always_comb begin
        nxt_wr    = i_wr;
        nxt_rd    = i_rd && !i_wr;
        nxt_addr  = (i_wr || i_rd) ? i_addr : addr_ff;
        nxt_wd    = i_wr ? i_wdata : wd_ff;
        nxt_rdv   = rd_ff;
        nxt_rdata = rdv_ff ? bus.data : rdata_ff;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            wr_ff    <= 1'b0;
            rd_ff    <= 1'b0;
            addr_ff  <= 3'h0;
            wd_ff    <= 8'h00;
            rdata_ff <= 8'h00;
            rdv_ff   <= 1'b0;
        end else begin
            wr_ff    <= nxt_wr;
            rd_ff    <= nxt_rd;
            addr_ff  <= nxt_addr;
            wd_ff    <= nxt_wd;
            rdata_ff <= nxt_rdata;
            rdv_ff   <= nxt_rdv;
        end
    end

    // Held read strobe covers the device's registered answer cycle
    assign bus.chip_select_low_active_n = 1'b0;
    assign bus.chip_select_high_active  = 1'b1;
    assign bus.wr_n                     = !wr_ff;
    assign bus.rd_n                     = !(rd_ff || rdv_ff);
    assign bus.addr                     = addr_ff;
    assign bus.data_host_o              = wd_ff;
    assign bus.data_host_oe             = wr_ff;
    assign bus.rst_n                    = i_rstn;
    assign bus.clock_source_select      = i_clock_source_select;
    assign o_rdata                      = rdata_ff;
endmodule

// >>> tb/dmd_bus_monitor.sv
`timescale 1ns/1ps
module dmd_bus_monitor (
    input wire logic       i_clk,
    input wire logic       i_rstn,
    input wire logic       chip_select_low_active_n,
    input wire logic       chip_select_high_active,
    input wire logic       rd_n,
    input wire logic       wr_n,
    input wire logic [2:0] addr,
    input wire logic       data_host_oe,
    input wire logic       data_dev_oe
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    sel_held_a: assert property (!chip_select_low_active_n && chip_select_high_active)
        else $error("chip selects not held active");
    strobe_excl_a: assert property (rd_n || wr_n)
        else $error("read and write strobes low together");
    wr_len_a: assert property ($fell(wr_n) |=> wr_n)
        else $error("write strobe longer than one cycle");
    wr_data_a: assert property (!wr_n |-> data_host_oe && !data_dev_oe)
        else $error("write data not driven by host alone");
    rd_len_a: assert property ($fell(rd_n) |=> !rd_n ##1 rd_n)
        else $error("read strobe not two cycles long");
    rd_ans_a: assert property ($fell(rd_n) |=> data_dev_oe)
        else $error("device did not answer a read");
    dev_drive_a: assert property (data_dev_oe |-> !rd_n && !$past(rd_n))
        else $error("device drives data outside a read");
    addr_hold_a: assert property ($fell(rd_n) |=> $stable(addr))
        else $error("address moved during a read");
endmodule

// >>> tb/dot_matrix_control_word_attributes_tb.sv
`timescale 1ns/1ps
module dot_matrix_control_word_attributes_tb;
    import dmd_pkg::*;
    logic        i_clk, i_rstn, i_wr, i_rd, i_clock_source_select;
    logic [2:0]  i_addr;
    logic [7:0]  i_wdata, o_rdata, o_digit_level, o_digit_show;
    logic [27:0] o_char_code;
    logic        o_clock_internal;
    int          failures = 0, samples_checked = 0, cycles = 0;
    dmd_bus_if bus ();
    dmd_host dmd_host_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .i_clock_source_select(i_clock_source_select),
        .o_rdata(o_rdata), .bus(bus));
    dmd_display dmd_display_i (.i_clk(i_clk), .i_rstn(i_rstn), .bus(bus),
        .i_char_dots_sel(28'h0000000), .o_char_code(o_char_code), .o_digit_level(o_digit_level),
        .o_digit_show(o_digit_show), .o_clock_internal(o_clock_internal));
    dmd_bus_monitor dmd_bus_monitor_i (.i_clk(i_clk), .i_rstn(i_rstn),
        .chip_select_low_active_n(bus.chip_select_low_active_n),
        .chip_select_high_active(bus.chip_select_high_active), .rd_n(bus.rd_n),
        .wr_n(bus.wr_n), .addr(bus.addr), .data_host_oe(bus.data_host_oe),
        .data_dev_oe(bus.data_dev_oe));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // The 2 Hz blink period is far beyond this run, so blink phase stays at its reset value
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [27:0] seen, input logic [27:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        repeat (3) @(posedge i_clk);
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        i_addr <= a; i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        repeat (3) @(posedge i_clk);
        #1 check(28'(o_rdata), 28'(exp));
    endtask
    task automatic dig(input int i, input logic [1:0] sh, input logic [1:0] lv);
        check(28'(o_digit_show[2*i+:2]), 28'(sh));
        check(28'(o_digit_level[2*i+:2]), 28'(lv));
    endtask
    task automatic all_dig(input logic [1:0] sh, input logic [1:0] lv);
        for (int i = 0; i < 4; i++) dig(i, sh, lv);
    endtask
    // Even digits carry the attribute flag
    function automatic logic [7:0] code(input int i);
        return 8'h41 + 8'(i) + (i[0] ? 8'h00 : 8'h80);
    endfunction
    initial begin
        i_rstn = 1'b0; i_wr = 1'b0; i_rd = 1'b0; i_addr = 3'h0; i_wdata = 8'h00;
        i_clock_source_select = 1'b0;
        repeat (8) @(posedge i_clk);
        i_rstn <= 1'b1;
        check(28'(o_clock_internal), 28'h0);
        rdc(3'h0, 8'h00);
        for (int i = 0; i < 4; i++) wr(3'(4 + i), code(i));
        for (int i = 0; i < 4; i++) begin
            check(28'(o_char_code[7*i+:7]), 28'(code(i) & 8'h7F));
            rdc(3'(4 + i), code(i));
        end
        $display("digit test done");
        for (int b = 0; b < 4; b++) begin
            wr(3'(b), 8'(b));
            rdc(3'(3 - b), 8'(b));
            all_dig(DMD_SHOW_CHAR, 2'(b));
        end
        // Mode bits set but highlight disabled: flagged digits stay plain
        wr(3'h0, 8'h0F);
        all_dig(DMD_SHOW_CHAR, 2'h3);
        $display("brightness test done");
        for (int m = 0; m < 4; m++) begin
            wr(3'h0, 8'h13 | 8'(m << 2));
            for (int i = 0; i < 4; i++) begin
                check(28'(o_char_code[7*i+:7]), 28'(code(i) & 8'h7F));
                if (i[0] || m == 1) dig(i, DMD_SHOW_CHAR, 2'h3);
                else if (m != 3) dig(i, DMD_SHOW_CURSOR, 2'h2);
                else dig(i, DMD_SHOW_CHAR, 2'h3);
            end
        end
        wr(3'h0, 8'h03);
        all_dig(DMD_SHOW_CHAR, 2'h3);
        wr(3'h0, 8'h22);
        all_dig(DMD_SHOW_CHAR, 2'h2);
        wr(3'h0, 8'h41);
        all_dig(DMD_SHOW_CURSOR, 2'h2);
        wr(3'h0, 8'h01);
        all_dig(DMD_SHOW_CHAR, 2'h1);
        $display("attribute test done");
        i_clock_source_select <= 1'b1;
        repeat (2) @(posedge i_clk);
        check(28'(o_clock_internal), 28'h1);
        wr(3'h0, 8'h80);
        rdc(3'h0, 8'h00);
        rdc(3'h6, 8'h00);
        check(o_char_code, 28'h0000000);
        all_dig(DMD_SHOW_CHAR, 2'h0);
        wr(3'h1, 8'h03);
        rdc(3'h2, 8'h03);
        $display("clear test done");
        conclude();
    end
endmodule
